// file: rtl/dual_timer.sv
`timescale 1ns/1ps
`include "dual_timer_regs.svh"
module dual_timer
    import dual_timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_pin_zero,
    input  wire logic        count_pin_one,
    input  wire logic        ext_gate_pin_zero,
    input  wire logic        ext_gate_pin_one,
    input  wire logic        timer_zero_vector_ack,
    input  wire logic        timer_one_vector_ack,
    input  wire logic        ext_irq_zero_ack,
    input  wire logic        ext_irq_one_ack,
    output logic             timer_zero_overflow_flag,
    output logic             timer_one_overflow_flag,
    output logic             ext_irq_zero_edge_flag,
    output logic             ext_irq_one_edge_flag,
    output logic             timer_one_baud_pulse
);
    // ****************************************
    // State
    // ****************************************
    logic [7:0]  timer_control;
    logic [7:0]  timer_mode_control;
    logic [7:0]  timer_zero_count_low;
    logic [7:0]  timer_zero_count_high;
    logic [7:0]  timer_one_count_low;
    logic [7:0]  timer_one_count_high;
    logic [7:0]  timer_zero_reload_low;
    logic [7:0]  timer_zero_reload_high;
    logic [7:0]  timer_one_reload_low;
    logic [7:0]  timer_one_reload_high;
    logic [3:0]  shared_timer_prescale;
    logic [7:0]  next_control;
    logic [7:0]  next_mode;
    logic [7:0]  next_t0_low;
    logic [7:0]  next_t0_high;
    logic [7:0]  next_t1_low;
    logic [7:0]  next_t1_high;
    logic [7:0]  next_r0_low;
    logic [7:0]  next_r0_high;
    logic [7:0]  next_r1_low;
    logic [7:0]  next_r1_high;
    logic [3:0]  next_prescale;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_baud;

    timer_cfg_s  cfg0;
    timer_cfg_s  cfg1;
    pin_sample_s cnt0_s;
    pin_sample_s cnt1_s;
    pin_sample_s xpin0_s;
    pin_sample_s xpin1_s;
    logic        tick;
    logic        run0;
    logic        run1;
    logic        inc0;
    logic        inc1;
    logic        inc_split_high;
    logic        ov0;
    logic        ov1;
    logic        ov_split_high;
    logic [9:0]  idx;
    logic        hit;
    logic [7:0]  rd_byte;
    logic        wr_en;

    // ****************************************
    // Pin sampling and prescaler
    // ****************************************
    sample_fall_detect u_cnt0 (.clk(pclk), .rst_n(presetn), .pin(count_pin_zero),
                               .smp(cnt0_s));
    sample_fall_detect u_cnt1 (.clk(pclk), .rst_n(presetn), .pin(count_pin_one),
                               .smp(cnt1_s));
    sample_fall_detect u_xpin0 (.clk(pclk), .rst_n(presetn), .pin(ext_gate_pin_zero),
                                .smp(xpin0_s));
    sample_fall_detect u_xpin1 (.clk(pclk), .rst_n(presetn), .pin(ext_gate_pin_one),
                                .smp(xpin1_s));
    prescale_tick u_tick (.clk(pclk), .rst_n(presetn), .prescale(shared_timer_prescale),
                          .tick(tick));

    // ****************************************
    // Mode decode and count enables
    // ****************************************
    assign cfg0.gate      = timer_mode_control[`MOD_T0_GATE];
    assign cfg0.count_ext = timer_mode_control[`MOD_T0_EXT];
    assign cfg0.mode      = mode_e'({timer_mode_control[`MOD_T0_HI],
                                     timer_mode_control[`MOD_T0_LO]});
    assign cfg1.gate      = timer_mode_control[`MOD_T1_GATE];
    assign cfg1.count_ext = timer_mode_control[`MOD_T1_EXT];
    assign cfg1.mode      = mode_e'({timer_mode_control[`MOD_T1_HI],
                                     timer_mode_control[`MOD_T1_LO]});

    assign run0 = timer_control[`CTL_RUN0] & (~cfg0.gate | xpin0_s.level);
    assign run1 = timer_control[`CTL_RUN1] & (~cfg1.gate | xpin1_s.level)
                  & (cfg1.mode != MODE_SPLIT);
    assign inc0 = run0 & (cfg0.count_ext ? cnt0_s.fall : tick);
    assign inc1 = run1 & (cfg1.count_ext ? cnt1_s.fall : tick);
    assign inc_split_high = (cfg0.mode == MODE_SPLIT) & timer_control[`CTL_RUN1] & tick;

    // ****************************************
    // APB decode
    // ****************************************
    assign idx   = paddr[11:2];
    assign wr_en = psel & penable & pready & pwrite & hit;

    always_comb begin
        hit     = (paddr[1:0] == 2'b00);
        rd_byte = `RST_BYTE;
        unique case (idx)
            `IDX_TIMER_CONTROL:      rd_byte = timer_control;
            `IDX_TIMER_MODE_CONTROL: rd_byte = timer_mode_control;
            `IDX_T0_COUNT_LOW:       rd_byte = timer_zero_count_low;
            `IDX_T1_COUNT_LOW:       rd_byte = timer_one_count_low;
            `IDX_T0_COUNT_HIGH:      rd_byte = timer_zero_count_high;
            `IDX_T1_COUNT_HIGH:      rd_byte = timer_one_count_high;
            `IDX_T0_RELOAD_LOW:      rd_byte = timer_zero_reload_low;
            `IDX_T1_RELOAD_LOW:      rd_byte = timer_one_reload_low;
            `IDX_T0_RELOAD_HIGH:     rd_byte = timer_zero_reload_high;
            `IDX_T1_RELOAD_HIGH:     rd_byte = timer_one_reload_high;
            `IDX_PRESCALE:           rd_byte = {4'h0, shared_timer_prescale};
            default:                 hit = 1'b0;
        endcase
    end

    always_comb begin
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~hit;
        next_prdata  = (psel & ~penable & ~pwrite & hit) ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // ****************************************
    // Counters
    // ****************************************
    always_comb begin
        next_t0_low   = timer_zero_count_low;
        next_t0_high  = timer_zero_count_high;
        next_t1_low   = timer_one_count_low;
        next_t1_high  = timer_one_count_high;
        ov0           = 1'b0;
        ov1           = 1'b0;
        ov_split_high = 1'b0;
        unique case (cfg0.mode)
            MODE_VARIABLE: begin
            end
            MODE_RELOAD16: begin
                if (inc0) begin
                    if ({timer_zero_count_high, timer_zero_count_low} == `WORD_ONES) begin
                        next_t0_high = timer_zero_reload_high;
                        next_t0_low  = timer_zero_reload_low;
                        ov0          = 1'b1;
                    end else begin
                        {next_t0_high, next_t0_low} =
                            {timer_zero_count_high, timer_zero_count_low} + 16'h0001;
                    end
                end
            end
            MODE_RELOAD8: begin
                if (inc0) begin
                    if (timer_zero_count_low == `BYTE_ONES) begin
                        next_t0_low = timer_zero_count_high;
                        ov0         = 1'b1;
                    end else begin
                        next_t0_low = timer_zero_count_low + 8'h01;
                    end
                end
            end
            MODE_SPLIT: begin
                if (inc0) begin
                    next_t0_low = timer_zero_count_low + 8'h01;
                    ov0         = (timer_zero_count_low == `BYTE_ONES);
                end
                if (inc_split_high) begin
                    next_t0_high  = timer_zero_count_high + 8'h01;
                    ov_split_high = (timer_zero_count_high == `BYTE_ONES);
                end
            end
        endcase
        unique case (cfg1.mode)
            MODE_VARIABLE, MODE_SPLIT: begin
            end
            MODE_RELOAD16: begin
                if (inc1) begin
                    if ({timer_one_count_high, timer_one_count_low} == `WORD_ONES) begin
                        next_t1_high = timer_one_reload_high;
                        next_t1_low  = timer_one_reload_low;
                        ov1          = 1'b1;
                    end else begin
                        {next_t1_high, next_t1_low} =
                            {timer_one_count_high, timer_one_count_low} + 16'h0001;
                    end
                end
            end
            MODE_RELOAD8: begin
                if (inc1) begin
                    if (timer_one_count_low == `BYTE_ONES) begin
                        next_t1_low = timer_one_count_high;
                        ov1         = 1'b1;
                    end else begin
                        next_t1_low = timer_one_count_low + 8'h01;
                    end
                end
            end
        endcase
        // Software write wins over counting in the same cycle
        if (wr_en) begin
            if (idx == `IDX_T0_COUNT_LOW) next_t0_low = pwdata[7:0];
            if (idx == `IDX_T0_COUNT_HIGH) next_t0_high = pwdata[7:0];
            if (idx == `IDX_T1_COUNT_LOW) next_t1_low = pwdata[7:0];
            if (idx == `IDX_T1_COUNT_HIGH) next_t1_high = pwdata[7:0];
        end
        next_baud = ov1;
    end

    // ****************************************
    // Software-only registers
    // ****************************************
    always_comb begin
        next_mode     = timer_mode_control;
        next_r0_low   = timer_zero_reload_low;
        next_r0_high  = timer_zero_reload_high;
        next_r1_low   = timer_one_reload_low;
        next_r1_high  = timer_one_reload_high;
        next_prescale = shared_timer_prescale;
        if (wr_en) begin
            if (idx == `IDX_TIMER_MODE_CONTROL) next_mode = pwdata[7:0];
            if (idx == `IDX_T0_RELOAD_LOW) next_r0_low = pwdata[7:0];
            if (idx == `IDX_T0_RELOAD_HIGH) next_r0_high = pwdata[7:0];
            if (idx == `IDX_T1_RELOAD_LOW) next_r1_low = pwdata[7:0];
            if (idx == `IDX_T1_RELOAD_HIGH) next_r1_high = pwdata[7:0];
            if (idx == `IDX_PRESCALE) next_prescale = pwdata[3:0];
        end
    end

    // ****************************************
    // Control flags: write, then clear, then set
    // ****************************************
    always_comb begin
        next_control = timer_control;
        if (wr_en && idx == `IDX_TIMER_CONTROL) next_control = pwdata[7:0];
        if (timer_zero_vector_ack) next_control[`CTL_OVF0] = 1'b0;
        if (timer_one_vector_ack) next_control[`CTL_OVF1] = 1'b0;
        if (ext_irq_zero_ack) next_control[`CTL_EDGE0] = 1'b0;
        if (ext_irq_one_ack) next_control[`CTL_EDGE1] = 1'b0;
        if (ov0) next_control[`CTL_OVF0] = 1'b1;
        if ((ov1 && cfg0.mode != MODE_SPLIT) || ov_split_high) begin
            next_control[`CTL_OVF1] = 1'b1;
        end
        if (timer_control[`CTL_TYPE0]) begin
            if (xpin0_s.fall) next_control[`CTL_EDGE0] = 1'b1;
        end else begin
            next_control[`CTL_EDGE0] = ~xpin0_s.level;
        end
        if (timer_control[`CTL_TYPE1]) begin
            if (xpin1_s.fall) next_control[`CTL_EDGE1] = 1'b1;
        end else begin
            next_control[`CTL_EDGE1] = ~xpin1_s.level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control          <= `RST_BYTE;
            timer_mode_control     <= `RST_BYTE;
            timer_zero_count_low   <= `RST_BYTE;
            timer_zero_count_high  <= `RST_BYTE;
            timer_one_count_low    <= `RST_BYTE;
            timer_one_count_high   <= `RST_BYTE;
            timer_zero_reload_low  <= `RST_BYTE;
            timer_zero_reload_high <= `RST_BYTE;
            timer_one_reload_low   <= `RST_BYTE;
            timer_one_reload_high  <= `RST_BYTE;
            shared_timer_prescale  <= `RST_PRESCALE;
            prdata                 <= 32'h00000000;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            timer_one_baud_pulse   <= 1'b0;
        end else begin
            timer_control          <= next_control;
            timer_mode_control     <= next_mode;
            timer_zero_count_low   <= next_t0_low;
            timer_zero_count_high  <= next_t0_high;
            timer_one_count_low    <= next_t1_low;
            timer_one_count_high   <= next_t1_high;
            timer_zero_reload_low  <= next_r0_low;
            timer_zero_reload_high <= next_r0_high;
            timer_one_reload_low   <= next_r1_low;
            timer_one_reload_high  <= next_r1_high;
            shared_timer_prescale  <= next_prescale;
            prdata                 <= next_prdata;
            pready                 <= next_pready;
            pslverr                <= next_pslverr;
            timer_one_baud_pulse   <= next_baud;
        end
    end

    assign timer_zero_overflow_flag = timer_control[`CTL_OVF0];
    assign timer_one_overflow_flag  = timer_control[`CTL_OVF1];
    assign ext_irq_zero_edge_flag   = timer_control[`CTL_EDGE0];
    assign ext_irq_one_edge_flag    = timer_control[`CTL_EDGE1];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence wrap16_s;
        cfg0.mode == MODE_RELOAD16 && inc0 && !wr_en &&
        {timer_zero_count_high, timer_zero_count_low} == `WORD_ONES;
    endsequence
    sequence tick_gap_s;
        tick && shared_timer_prescale == 4'h1 && !wr_en ##1 !tick && !wr_en;
    endsequence

    reload16_wrap_a: assert property (wrap16_s |=>
        {timer_zero_count_high, timer_zero_count_low} ==
        $past({timer_zero_reload_high, timer_zero_reload_low}) && timer_control[`CTL_OVF0])
        else $error("16-bit wrap did not reload and flag");
    count16_step_a: assert property (cfg0.mode == MODE_RELOAD16 && inc0 && !wr_en &&
        {timer_zero_count_high, timer_zero_count_low} != `WORD_ONES |=>
        {timer_zero_count_high, timer_zero_count_low} ==
        $past({timer_zero_count_high, timer_zero_count_low}) + 16'h0001)
        else $error("16-bit count did not step by one");
    reload8_high_a: assert property (cfg0.mode == MODE_RELOAD8 && !wr_en |=>
        $stable(timer_zero_count_high))
        else $error("8-bit reload source changed");
    t1_split_hold_a: assert property (cfg1.mode == MODE_SPLIT && !wr_en |=>
        $stable({timer_one_count_high, timer_one_count_low}))
        else $error("timer 1 counted in mode 3");
    split_flag_block_a: assert property (cfg0.mode == MODE_SPLIT && !ov_split_high &&
        !timer_control[`CTL_OVF1] && !wr_en |=> !timer_control[`CTL_OVF1])
        else $error("timer 1 flag set while timer 0 split");
    split_high_flag_a: assert property (cfg0.mode == MODE_SPLIT && tick &&
        timer_control[`CTL_RUN1] && timer_zero_count_high == `BYTE_ONES && !wr_en |=>
        timer_control[`CTL_OVF1] && timer_zero_count_high == 8'h00)
        else $error("split high byte overflow missed");
    prescale_gap_a: assert property (tick_gap_s |=> tick)
        else $error("prescaler period wrong");
    gate_hold_a: assert property (cfg1.gate && !xpin1_s.level && !wr_en |=>
        $stable({timer_one_count_high, timer_one_count_low}))
        else $error("gated timer 1 counted");
    counter_pin_a: assert property (cfg0.count_ext && cfg0.mode == MODE_RELOAD16 &&
        !cnt0_s.fall && !wr_en |=> $stable({timer_zero_count_high, timer_zero_count_low}))
        else $error("counter advanced without pin fall");
    flag_set_wins_a: assert property (ov0 |=> timer_control[`CTL_OVF0])
        else $error("overflow lost against clear");
    ext_level_a: assert property (!timer_control[`CTL_TYPE0] && !wr_en |=>
        timer_control[`CTL_EDGE0] == !$past(xpin0_s.level))
        else $error("level-triggered flag wrong");
    ext_edge_a: assert property (timer_control[`CTL_TYPE0] && xpin0_s.fall |=>
        timer_control[`CTL_EDGE0])
        else $error("edge flag not set");
endmodule // dual_timer

// file: rtl/dual_timer_regs.svh
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define IDX_TIMER_CONTROL      10'h088
`define IDX_TIMER_MODE_CONTROL 10'h089
`define IDX_T0_COUNT_LOW       10'h08A
`define IDX_T1_COUNT_LOW       10'h08B
`define IDX_T0_COUNT_HIGH      10'h08C
`define IDX_T1_COUNT_HIGH      10'h08D
`define IDX_T0_RELOAD_LOW      10'h092
`define IDX_T1_RELOAD_LOW      10'h093
`define IDX_T0_RELOAD_HIGH     10'h094
`define IDX_T1_RELOAD_HIGH     10'h095
`define IDX_PRESCALE           10'h096

// ****************************************
// Control register fields
// ****************************************
`define CTL_OVF1  7
`define CTL_RUN1  6
`define CTL_OVF0  5
`define CTL_RUN0  4
`define CTL_EDGE1 3
`define CTL_TYPE1 2
`define CTL_EDGE0 1
`define CTL_TYPE0 0

// ****************************************
// Mode register fields
// ****************************************
`define MOD_T1_GATE 7
`define MOD_T1_EXT  6
`define MOD_T1_HI   5
`define MOD_T1_LO   4
`define MOD_T0_GATE 3
`define MOD_T0_EXT  2
`define MOD_T0_LO   1
`define MOD_T0_HI   0

// ****************************************
// Reset values and all-ones compare constants
// ****************************************
`define RST_BYTE     8'h00
`define RST_PRESCALE 4'h0
`define BYTE_ONES    8'hFF
`define WORD_ONES    16'hFFFF

`endif

// file: rtl/dual_timer_pkg.sv
package dual_timer_pkg;

    typedef enum logic [1:0] {
        MODE_VARIABLE,
        MODE_RELOAD16,
        MODE_RELOAD8,
        MODE_SPLIT
    } mode_e;

    typedef struct packed {
        logic  gate;
        logic  count_ext;
        mode_e mode;
    } timer_cfg_s;

    typedef struct packed {
        logic level;
        logic fall;
    } pin_sample_s;

endpackage

// file: rtl/sample_fall_detect.sv
`timescale 1ns/1ps
module sample_fall_detect
    import dual_timer_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  pin,
    output pin_sample_s smp
);
    logic now_q;
    logic prev_q;
    logic next_now;
    logic next_prev;

    always_comb begin
        next_now  = pin;
        next_prev = now_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            now_q  <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            now_q  <= next_now;
            prev_q <= next_prev;
        end
    end

    // High sample followed by low sample
    assign smp.level = now_q;
    assign smp.fall  = prev_q & ~now_q;
endmodule // sample_fall_detect

// file: rtl/prescale_tick.sv
`timescale 1ns/1ps
module prescale_tick (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] prescale,
    output logic            tick
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    // One tick every prescale+1 cycles
    always_comb begin
        next_cnt = (cnt >= prescale) ? 4'h0 : cnt + 4'h1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick = (cnt >= prescale);
endmodule // prescale_tick

// file: verif/dual_timer_tb.sv
`timescale 1ns/1ps
`include "dual_timer_regs.svh"
module dual_timer_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, err;
    logic        cnt0 = 1'b0, cnt1 = 1'b0, xpin0 = 1'b1, xpin1 = 1'b0;
    logic        ack_t0 = 1'b0, ack_t1 = 1'b0, ack_e0 = 1'b0, ack_e1 = 1'b0;
    logic        ovf0, ovf1, xfl0, xfl1, baud;
    logic [7:0]  rd, keep;
    int          fails = 0, num_checks = 0, cyc = 0;

    always #2.5 pclk = ~pclk;

    dual_timer dual_timer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .count_pin_zero(cnt0), .count_pin_one(cnt1),
        .ext_gate_pin_zero(xpin0), .ext_gate_pin_one(xpin1),
        .timer_zero_vector_ack(ack_t0), .timer_one_vector_ack(ack_t1),
        .ext_irq_zero_ack(ack_e0), .ext_irq_one_ack(ack_e1),
        .timer_zero_overflow_flag(ovf0), .timer_one_overflow_flag(ovf1),
        .ext_irq_zero_edge_flag(xfl0), .ext_irq_one_edge_flag(xfl1),
        .timer_one_baud_pulse(baud));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask

    task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [9:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask

    task rc(input logic [9:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(rd, e);
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test;
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc(`IDX_TIMER_MODE_CONTROL, 8'h00);
        rc(`IDX_T0_RELOAD_LOW, 8'h00);
        rc(`IDX_T0_RELOAD_HIGH, 8'h00);
        rc(`IDX_T1_RELOAD_LOW, 8'h00);
        rc(`IDX_T1_RELOAD_HIGH, 8'h00);
        apb(1'b0, 10'h3FF, 8'h00);
        chk({7'h0, err}, 8'h01);
        $display("reset and map test done");
        wr(`IDX_PRESCALE, 8'h0F);
        wr(`IDX_T0_COUNT_LOW, 8'hFE);
        wr(`IDX_T0_COUNT_HIGH, 8'hFF);
        wr(`IDX_T0_RELOAD_LOW, 8'h34);
        wr(`IDX_T0_RELOAD_HIGH, 8'h12);
        wr(`IDX_TIMER_MODE_CONTROL, 8'h02);
        wr(`IDX_TIMER_CONTROL, 8'h10);
        while (ovf0 !== 1'b1) @(posedge pclk);
        chk({7'h0, baud}, 8'h00);
        rc(`IDX_T0_COUNT_LOW, 8'h34);
        rc(`IDX_T0_COUNT_HIGH, 8'h12);
        ack_t0 <= 1'b1;
        @(posedge pclk);
        ack_t0 <= 1'b0;
        @(posedge pclk);
        chk({7'h0, ovf0}, 8'h00);
        $display("sixteen bit reload test done");
        wr(`IDX_TIMER_CONTROL, 8'h00);
        wr(`IDX_TIMER_MODE_CONTROL, 8'h20);
        wr(`IDX_T1_COUNT_LOW, 8'hFE);
        wr(`IDX_T1_COUNT_HIGH, 8'h80);
        wr(`IDX_T1_RELOAD_LOW, 8'h55);
        wr(`IDX_TIMER_CONTROL, 8'h40);
        while (ovf1 !== 1'b1) @(posedge pclk);
        chk({7'h0, baud}, 8'h01);
        rc(`IDX_T1_COUNT_LOW, 8'h80);
        rc(`IDX_T1_COUNT_HIGH, 8'h80);
        rc(`IDX_T1_RELOAD_LOW, 8'h55);
        ack_t1 <= 1'b1;
        @(posedge pclk);
        ack_t1 <= 1'b0;
        @(posedge pclk);
        chk({7'h0, ovf1}, 8'h00);
        wr(`IDX_TIMER_MODE_CONTROL, 8'hA0);
        apb(1'b0, `IDX_T1_COUNT_LOW, 8'h00);
        keep = rd;
        repeat (40) @(posedge pclk);
        rc(`IDX_T1_COUNT_LOW, keep);
        xpin1 <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, `IDX_T1_COUNT_LOW, 8'h00);
        chk({7'h0, rd !== keep}, 8'h01);
        $display("eight bit reload and gate test done");
        wr(`IDX_TIMER_CONTROL, 8'h00);
        wr(`IDX_TIMER_MODE_CONTROL, 8'h33);
        wr(`IDX_T0_COUNT_HIGH, 8'hFE);
        apb(1'b0, `IDX_T1_COUNT_LOW, 8'h00);
        keep = rd;
        wr(`IDX_TIMER_CONTROL, 8'h40);
        while (ovf1 !== 1'b1) @(posedge pclk);
        chk({7'h0, baud}, 8'h00);
        rc(`IDX_T0_COUNT_HIGH, 8'h00);
        rc(`IDX_T1_COUNT_LOW, keep);
        chk({7'h0, ovf0}, 8'h00);
        wr(`IDX_TIMER_MODE_CONTROL, 8'h23);
        repeat (40) @(posedge pclk);
        apb(1'b0, `IDX_T1_COUNT_LOW, 8'h00);
        chk({7'h0, rd !== keep}, 8'h01);
        wr(`IDX_TIMER_CONTROL, 8'h40);
        wr(`IDX_T1_COUNT_LOW, 8'hFE);
        while (baud !== 1'b1) @(posedge pclk);
        chk({7'h0, ovf1}, 8'h00);
        $display("split mode test done");
        wr(`IDX_TIMER_CONTROL, 8'h01);
        xpin0 <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({7'h0, xfl0}, 8'h01);
        ack_e0 <= 1'b1;
        @(posedge pclk);
        ack_e0 <= 1'b0;
        @(posedge pclk);
        chk({7'h0, xfl0}, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        repeat (3) @(posedge pclk);
        chk({7'h0, xfl0}, 8'h01);
        xpin0 <= 1'b1;
        $display("external flag test done");
        wr(`IDX_PRESCALE, 8'h01);
        rc(`IDX_PRESCALE, 8'h01);
        wr(`IDX_TIMER_MODE_CONTROL, 8'h05);
        wr(`IDX_T0_COUNT_LOW, 8'h00);
        wr(`IDX_T0_COUNT_HIGH, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h10);
        for (int k = 0; k < 3; k++) begin
            cnt0 <= 1'b1;
            repeat (2) @(posedge pclk);
            cnt0 <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        rc(`IDX_T0_COUNT_LOW, 8'h03);
        $display("counter pin test done");
        stop_test;
    end
endmodule // dual_timer_tb
